// *** rtl/gpcd_pkg.sv ***
/*
  Constants for the two-port pin control block: register offsets, field
  layouts, reset values and encodings.
  Assumes an APB3 master with 32-bit data and full-word accesses.
*/
package gpcd_pkg;

  localparam int ADDR_W = 12;
  localparam int C_PINS = 16;
  localparam int D_PINS = 5;
  localparam int AF_NUM = 6;
  localparam int FSEL_W = 4;

  ////////////////////////////////////////////////////////////////////////
  localparam logic [11:0] OFF_C_FSEL_LO = 12'h240;
  localparam logic [11:0] OFF_C_FSEL_HI = 12'h244;
  localparam logic [11:0] OFF_C_IRQ_EN = 12'h260;
  localparam logic [11:0] OFF_C_IRQ_SENSE = 12'h264;
  localparam logic [11:0] OFF_C_IRQ_DUAL = 12'h268;
  localparam logic [11:0] OFF_C_IRQ_POL = 12'h26C;
  localparam logic [11:0] OFF_C_IRQ_FLAG = 12'h270;
  localparam logic [11:0] OFF_D_MODE = 12'h300;
  localparam logic [11:0] OFF_D_PULL = 12'h308;
  localparam logic [11:0] OFF_D_OUT = 12'h310;
  localparam logic [11:0] OFF_D_IN = 12'h314;
  localparam logic [11:0] OFF_D_DRV_TYPE = 12'h318;
  localparam logic [11:0] OFF_D_DRV_STR = 12'h31C;
  localparam logic [11:0] OFF_D_BIT_CLR = 12'h320;
  localparam logic [11:0] OFF_D_BIT_SET = 12'h324;
  localparam logic [11:0] OFF_D_BIT_INV = 12'h328;
  localparam logic [11:0] OFF_D_FSEL = 12'h340;
  localparam logic [11:0] OFF_D_IRQ_EN = 12'h360;
  localparam logic [11:0] OFF_D_IRQ_SENSE = 12'h364;
  localparam logic [11:0] OFF_D_IRQ_DUAL = 12'h368;
  localparam logic [11:0] OFF_D_IRQ_POL = 12'h36C;
  localparam logic [11:0] OFF_D_IRQ_FLAG = 12'h370;

  ////////////////////////////////////////////////////////////////////////
  localparam logic [9:0] D_MODE_RST = 10'h3FF;
  localparam logic [1:0] MODE_INPUT = 2'h0;
  localparam logic [1:0] MODE_OUTPUT = 2'h1;
  localparam logic [1:0] MODE_ALT = 2'h2;
  localparam logic [1:0] MODE_ANALOG = 2'h3;
  localparam logic [1:0] PULL_UP = 2'h1;
  localparam logic [1:0] PULL_DOWN = 2'h2;
  localparam int NO_PULLDOWN_PIN = 1;

endpackage

// *** rtl/gpcd_top.sv ***
/*
  Register block and pin logic for the upper register set of the 16-pin
  port and all registers of the 5-pin port, behind an APB3 slave.
  Assumes pin inputs synchronous to clk_sys and full-word APB accesses.
*/
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
module gpcd_top (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gpcd_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] portc_pin_in,
  output logic [63:0] portc_func_sel,
  output logic [15:0] portc_irq_req,
  input wire logic [4:0] portd_pin_in,
  input wire logic [29:0] portd_af_out,
  input wire logic [29:0] portd_af_oe,
  output logic [4:0] portd_pin_o,
  output logic [4:0] portd_pin_oe_b,
  output logic [4:0] portd_pull_up,
  output logic [4:0] portd_pull_down,
  output logic [4:0] portd_analog_en,
  output logic [4:0] portd_drive_high,
  output logic [19:0] portd_func_sel,
  output logic [4:0] portd_irq_req
);

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [63:0] c_fsel;
    logic [15:0] c_ie;
    logic [15:0] c_iss;
    logic [15:0] c_bet;
    logic [15:0] c_trg;
    logic [15:0] c_if;
    logic [15:0] c_in;
    logic [15:0] c_prev;
    logic [15:0] c_irq;
    logic [9:0] d_mode;
    logic [9:0] d_pull;
    logic [4:0] d_out;
    logic [4:0] d_ot;
    logic [4:0] d_ds;
    logic [19:0] d_fsel;
    logic [4:0] d_ie;
    logic [4:0] d_iss;
    logic [4:0] d_bet;
    logic [4:0] d_trg;
    logic [4:0] d_if;
    logic [4:0] d_in;
    logic [4:0] d_prev;
    logic [4:0] d_irq;
    logic [4:0] d_pin_o;
    logic [4:0] d_pin_oe_b;
    logic [4:0] d_pu;
    logic [4:0] d_pd;
    logic [4:0] d_ana;
  } gpcd_state_t;

  gpcd_state_t st_q;
  gpcd_state_t st_d;
  logic acc_set;
  logic acc_go;
  logic wr_go;
  logic mapped;
  logic [31:0] rd_val;
  logic [15:0] c_clr;
  logic [4:0] d_clr;
  logic [15:0] c_hit;
  logic [15:0] d_hit;
  logic [1:0] pmode;
  logic [3:0] psel_af;
  logic pval;
  logic pen;

  // one wait state keeps pready, prdata and pslverr straight from flops
  assign acc_set = psel & penable & ~st_q.pready;
  assign acc_go = psel & penable & st_q.pready;
  assign wr_go = acc_go & pwrite;

  ////////////////////////////////////////////////////////////////////////
  // condition detect on 16-bit vectors; the small port is zero-padded
  function automatic logic [15:0] detect(
    input logic [15:0] cur,
    input logic [15:0] prev,
    input logic [15:0] iss,
    input logic [15:0] bet,
    input logic [15:0] trg
  );
    logic [15:0] rise;
    logic [15:0] fall;
    logic [15:0] lvl;
    logic [15:0] edg;
    rise = cur & ~prev;
    fall = ~cur & prev;
    lvl = (trg & cur) | (~trg & ~cur);
    edg = (bet & (rise | fall)) | (~bet & ((trg & rise) | (~trg & fall)));
    // level sense ignores the dual-edge bit
    detect = (iss & lvl) | (~iss & edg);
  endfunction

  assign c_hit = detect(st_q.c_in, st_q.c_prev, st_q.c_iss, st_q.c_bet,
                        st_q.c_trg);
  assign d_hit = detect({11'h000, st_q.d_in}, {11'h000, st_q.d_prev},
                        {11'h000, st_q.d_iss}, {11'h000, st_q.d_bet},
                        {11'h000, st_q.d_trg});

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      gpcd_pkg::OFF_C_FSEL_LO: rd_val = st_q.c_fsel[31:0];
      gpcd_pkg::OFF_C_FSEL_HI: rd_val = st_q.c_fsel[63:32];
      gpcd_pkg::OFF_C_IRQ_EN: rd_val = {16'h0000, st_q.c_ie};
      gpcd_pkg::OFF_C_IRQ_SENSE: rd_val = {16'h0000, st_q.c_iss};
      gpcd_pkg::OFF_C_IRQ_DUAL: rd_val = {16'h0000, st_q.c_bet};
      gpcd_pkg::OFF_C_IRQ_POL: rd_val = {16'h0000, st_q.c_trg};
      gpcd_pkg::OFF_C_IRQ_FLAG: rd_val = {16'h0000, st_q.c_if};
      gpcd_pkg::OFF_D_MODE: rd_val = {22'h000000, st_q.d_mode};
      gpcd_pkg::OFF_D_PULL: rd_val = {22'h000000, st_q.d_pull};
      gpcd_pkg::OFF_D_OUT: rd_val = {27'h0000000, st_q.d_out};
      gpcd_pkg::OFF_D_IN: rd_val = {27'h0000000, st_q.d_in};
      gpcd_pkg::OFF_D_DRV_TYPE: rd_val = {27'h0000000, st_q.d_ot};
      gpcd_pkg::OFF_D_DRV_STR: rd_val = 32'h0000_0000;
      gpcd_pkg::OFF_D_BIT_CLR: rd_val = 32'h0000_0000;
      gpcd_pkg::OFF_D_BIT_SET: rd_val = 32'h0000_0000;
      gpcd_pkg::OFF_D_BIT_INV: rd_val = 32'h0000_0000;
      gpcd_pkg::OFF_D_FSEL: rd_val = {12'h000, st_q.d_fsel};
      gpcd_pkg::OFF_D_IRQ_EN: rd_val = {27'h0000000, st_q.d_ie};
      gpcd_pkg::OFF_D_IRQ_SENSE: rd_val = {27'h0000000, st_q.d_iss};
      gpcd_pkg::OFF_D_IRQ_DUAL: rd_val = {27'h0000000, st_q.d_bet};
      gpcd_pkg::OFF_D_IRQ_POL: rd_val = {27'h0000000, st_q.d_trg};
      gpcd_pkg::OFF_D_IRQ_FLAG: rd_val = {27'h0000000, st_q.d_if};
      default: mapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    c_clr = 16'h0000;
    d_clr = 5'h00;
    pmode = 2'h0;
    psel_af = 4'h0;
    pval = 1'b0;
    pen = 1'b0;
    st_d.pready = acc_set;
    st_d.pslverr = acc_set & ~mapped;
    if (acc_set) begin
      st_d.prdata = pwrite ? 32'h0000_0000 : rd_val;
    end
    // every clock samples the pins; previous sample feeds edge detect
    st_d.c_in = portc_pin_in;
    st_d.c_prev = st_q.c_in;
    st_d.d_in = portd_pin_in;
    st_d.d_prev = st_q.d_in;
    if (wr_go) begin
      case (paddr)
        gpcd_pkg::OFF_C_FSEL_LO: st_d.c_fsel[31:0] = pwdata;
        gpcd_pkg::OFF_C_FSEL_HI: st_d.c_fsel[63:32] = pwdata;
        gpcd_pkg::OFF_C_IRQ_EN: st_d.c_ie = pwdata[15:0];
        gpcd_pkg::OFF_C_IRQ_SENSE: st_d.c_iss = pwdata[15:0];
        gpcd_pkg::OFF_C_IRQ_DUAL: st_d.c_bet = pwdata[15:0];
        gpcd_pkg::OFF_C_IRQ_POL: st_d.c_trg = pwdata[15:0];
        gpcd_pkg::OFF_C_IRQ_FLAG: c_clr = pwdata[15:0];
        gpcd_pkg::OFF_D_MODE: st_d.d_mode = pwdata[9:0];
        gpcd_pkg::OFF_D_PULL: st_d.d_pull = pwdata[9:0];
        gpcd_pkg::OFF_D_OUT: st_d.d_out = pwdata[4:0];
        gpcd_pkg::OFF_D_DRV_TYPE: st_d.d_ot = pwdata[4:0];
        gpcd_pkg::OFF_D_DRV_STR: st_d.d_ds = pwdata[4:0];
        gpcd_pkg::OFF_D_BIT_CLR: st_d.d_out = st_q.d_out & ~pwdata[4:0];
        gpcd_pkg::OFF_D_BIT_SET: st_d.d_out = st_q.d_out | pwdata[4:0];
        gpcd_pkg::OFF_D_BIT_INV: st_d.d_out = st_q.d_out ^ pwdata[4:0];
        gpcd_pkg::OFF_D_FSEL: st_d.d_fsel = pwdata[19:0];
        gpcd_pkg::OFF_D_IRQ_EN: st_d.d_ie = pwdata[4:0];
        gpcd_pkg::OFF_D_IRQ_SENSE: st_d.d_iss = pwdata[4:0];
        gpcd_pkg::OFF_D_IRQ_DUAL: st_d.d_bet = pwdata[4:0];
        gpcd_pkg::OFF_D_IRQ_POL: st_d.d_trg = pwdata[4:0];
        gpcd_pkg::OFF_D_IRQ_FLAG: d_clr = pwdata[4:0];
        default: st_d.c_in = portc_pin_in;
      endcase
    end
    // set wins over a clear in the same cycle, enable or not
    st_d.c_if = (st_q.c_if & ~c_clr) | c_hit;
    st_d.d_if = (st_q.d_if & ~d_clr) | d_hit[4:0];
    st_d.c_irq = st_d.c_if & st_d.c_ie;
    st_d.d_irq = st_d.d_if & st_d.d_ie;
    // pin drive follows the new configuration so outputs line up with it
    for (int i = 0; i < gpcd_pkg::D_PINS; i++) begin
      pmode = st_d.d_mode[2*i +: 2];
      psel_af = st_d.d_fsel[gpcd_pkg::FSEL_W*i +: gpcd_pkg::FSEL_W];
      pval = st_d.d_out[i];
      pen = 1'b0;
      if (pmode == gpcd_pkg::MODE_OUTPUT) begin
        pen = 1'b1;
      end else if (pmode == gpcd_pkg::MODE_ALT) begin
        // reserved selections leave the pin undriven
        if (psel_af < 4'(gpcd_pkg::AF_NUM)) begin
          pval = portd_af_out[i*gpcd_pkg::AF_NUM + int'(psel_af)];
          pen = portd_af_oe[i*gpcd_pkg::AF_NUM + int'(psel_af)];
        end
      end
      // open drain only ever pulls low; high comes from a pull-up
      st_d.d_pin_o[i] = pval & ~st_d.d_ot[i];
      st_d.d_pin_oe_b[i] = ~(pen & (~st_d.d_ot[i] | ~pval));
      st_d.d_ana[i] = (pmode == gpcd_pkg::MODE_ANALOG);
      st_d.d_pu[i] = ~st_d.d_ana[i] &
                     (st_d.d_pull[2*i +: 2] == gpcd_pkg::PULL_UP);
      st_d.d_pd[i] = ~st_d.d_ana[i] & (i != gpcd_pkg::NO_PULLDOWN_PIN) &
                     (st_d.d_pull[2*i +: 2] == gpcd_pkg::PULL_DOWN);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st_q <= '0;
      st_q.d_mode <= gpcd_pkg::D_MODE_RST;
      st_q.d_ana <= 5'h1F;
      st_q.d_pin_oe_b <= 5'h1F;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign portc_func_sel = st_q.c_fsel;
  assign portc_irq_req = st_q.c_irq;
  assign portd_pin_o = st_q.d_pin_o;
  assign portd_pin_oe_b = st_q.d_pin_oe_b;
  assign portd_pull_up = st_q.d_pu;
  assign portd_pull_down = st_q.d_pd;
  assign portd_analog_en = st_q.d_ana;
  assign portd_drive_high = st_q.d_ds;
  assign portd_func_sel = st_q.d_fsel;
  assign portd_irq_req = st_q.d_irq;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  irq_gate_a: assert property (
    portd_irq_req == (st_q.d_if & st_q.d_ie) &&
    portc_irq_req == (st_q.c_if & st_q.c_ie))
    else $error("irq request not flag and enable");
  mode_reset_a: assert property ($rose(rst_b) |->
    st_q.d_mode == gpcd_pkg::D_MODE_RST && portd_analog_en == 5'h1F)
    else $error("mode not analog after reset");
  fsel_reset_a: assert property ($rose(rst_b) |->
    portc_func_sel == 64'h0 && portd_func_sel == 20'h00000)
    else $error("function select not zero after reset");
  flag_set_a: assert property (c_hit[0] |=> st_q.c_if[0])
    else $error("event lost on raw flag");
  flag_clear_a: assert property (
    wr_go && paddr == gpcd_pkg::OFF_D_IRQ_FLAG && pwdata[0] && !d_hit[0]
    |=> !st_q.d_if[0])
    else $error("one written to flag did not clear it");
  level_refire_a: assert property (
    st_q.d_iss[0] && st_q.d_trg[0] && st_q.d_in[0] |=> st_q.d_if[0])
    else $error("level did not re-raise flag");
  bit_set_a: assert property (
    wr_go && paddr == gpcd_pkg::OFF_D_BIT_SET && pwdata[2] |=> st_q.d_out[2])
    else $error("bit set ignored");
  bit_inv_a: assert property (
    wr_go && paddr == gpcd_pkg::OFF_D_BIT_INV && pwdata[3]
    |=> st_q.d_out[3] != $past(st_q.d_out[3]))
    else $error("bit invert ignored");
  open_drain_a: assert property (
    st_q.d_ot[0] && !portd_pin_oe_b[0] |-> !portd_pin_o[0])
    else $error("open drain drove high");
  no_pulldown_a: assert property (!portd_pull_down[1])
    else $error("pull-down on pin one");
  sample_in_a: assert property (st_q.d_in == $past(portd_pin_in, 1))
    else $error("input not sampled");
  apb_answer_a: assert property (acc_set |=> pready ##1 !pready)
    else $error("apb answer timing");
  bit_clr_a: assert property (
    wr_go && paddr == gpcd_pkg::OFF_D_BIT_CLR && pwdata[1] |=> !st_q.d_out[1])
    else $error("bit clear ignored");
  out_write_a: assert property (
    wr_go && paddr == gpcd_pkg::OFF_D_OUT |=> st_q.d_out == 5'($past(pwdata)))
    else $error("output data write lost");
  fsel_write_a: assert property (
    wr_go && paddr == gpcd_pkg::OFF_D_FSEL
    |=> portd_func_sel == 20'($past(pwdata)))
    else $error("function select write lost");
  w1c_zero_a: assert property (
    wr_go && paddr == gpcd_pkg::OFF_C_IRQ_FLAG && !pwdata[2] && st_q.c_if[2]
    |=> st_q.c_if[2])
    else $error("zero written to flag cleared it");
  fall_edge_a: assert property (
    !st_q.c_iss[1] && !st_q.c_bet[1] && !st_q.c_trg[1] &&
    !st_q.c_in[1] && st_q.c_prev[1] |=> st_q.c_if[1])
    else $error("falling edge missed");
  dual_edge_a: assert property (
    !st_q.c_iss[2] && st_q.c_bet[2] && (st_q.c_in[2] != st_q.c_prev[2])
    |=> st_q.c_if[2])
    else $error("dual edge missed");
  level_dual_a: assert property (
    st_q.c_iss[4] && st_q.c_bet[4] && !st_q.c_trg[4] && !st_q.c_in[4]
    |=> st_q.c_if[4])
    else $error("dual-edge bit disturbed level sense");
  sample_c_a: assert property (st_q.c_in == $past(portc_pin_in))
    else $error("16-pin input not sampled");
  reserved_af_a: assert property (
    st_q.d_mode[9:8] == gpcd_pkg::MODE_ALT &&
    st_q.d_fsel[19:16] >= 4'(gpcd_pkg::AF_NUM) |-> portd_pin_oe_b[4])
    else $error("reserved function drove the pin");
  push_pull_a: assert property (
    st_q.d_mode[1:0] == gpcd_pkg::MODE_OUTPUT && !st_q.d_ot[0]
    |-> !portd_pin_oe_b[0] && portd_pin_o[0] == st_q.d_out[0])
    else $error("push-pull pin not driven from output data");
  input_release_a: assert property (
    st_q.d_mode[3:2] == gpcd_pkg::MODE_INPUT |-> portd_pin_oe_b[1])
    else $error("input pin driven");
  analog_off_a: assert property (
    st_q.d_mode[5:4] == gpcd_pkg::MODE_ANALOG
    |-> portd_analog_en[2] && portd_pin_oe_b[2])
    else $error("analog pin not isolated");
  pull_up_a: assert property (
    st_q.d_pull[7:6] == gpcd_pkg::PULL_UP &&
    st_q.d_mode[7:6] != gpcd_pkg::MODE_ANALOG |-> portd_pull_up[3])
    else $error("pull-up not enabled");

  flag_cover_c: cover property (c_hit[3] && portc_irq_req[3]);
  inv_cover_c: cover property (wr_go && paddr == gpcd_pkg::OFF_D_BIT_INV);
  err_cover_c: cover property (pslverr && pready);
  alt_cover_c: cover property (portd_pin_oe_b[3] == 1'b0 &&
                               st_q.d_mode[7:6] == gpcd_pkg::MODE_ALT);
  dual_cover_c: cover property (st_q.c_bet[2] && c_hit[2] && !st_q.c_in[2]);

endmodule

// *** test/gpcd_pin_model.sv ***
/*
  Pin-side model of the 5-pin port: resolves each pad level from the
  block's drive, its pull enables and an external level set by the bench.
  Assumes the bench owns the external levels and the 16-pin port inputs.
*/
`timescale 1ns/10ps
module gpcd_pin_model (
  input wire logic [4:0] portd_pin_o,
  input wire logic [4:0] portd_pin_oe_b,
  input wire logic [4:0] portd_pull_up,
  input wire logic [4:0] portd_pull_down,
  input wire logic [4:0] ext_level,
  output logic [4:0] portd_pin_in,
  output logic [29:0] portd_af_out,
  output logic [29:0] portd_af_oe
);
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (!portd_pin_oe_b[i]) begin
        portd_pin_in[i] = portd_pin_o[i];
      end else if (portd_pull_up[i]) begin
        portd_pin_in[i] = 1'b1;
      end else if (portd_pull_down[i]) begin
        portd_pin_in[i] = 1'b0;
      end else begin
        portd_pin_in[i] = ext_level[i];
      end
    end
  end
  // every peripheral drives; odd function numbers send a one
  assign portd_af_out = 30'h2AAAAAAA;
  assign portd_af_oe = 30'h3FFFFFFF;
endmodule

// *** test/testbench.sv ***
/*
  Self-checking bench for the two-port pin control block over APB.
  Assumes the pin model on the 5-pin port and a 20 MHz clock.
*/
`timescale 1ns/10ps
module testbench;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] portc_pin_in = 16'h0000;
  logic [4:0] ext_level = 5'h00;
  logic [63:0] portc_func_sel;
  logic [15:0] portc_irq_req;
  logic [19:0] portd_func_sel;
  logic [29:0] portd_af_out, portd_af_oe;
  logic [4:0] portd_pin_in, portd_pin_o, portd_pin_oe_b, portd_pull_up;
  logic [4:0] portd_pull_down, portd_analog_en, portd_drive_high;
  logic [4:0] portd_irq_req;
  logic [31:0] rdat;
  logic rerr;
  int failures = 0;
  int tests_run = 0;

  always #25 clk_sys = ~clk_sys;

  gpcd_top u_gpcd_top (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .portc_pin_in, .portc_func_sel,
    .portc_irq_req, .portd_pin_in, .portd_af_out, .portd_af_oe,
    .portd_pin_o, .portd_pin_oe_b, .portd_pull_up, .portd_pull_down,
    .portd_analog_en, .portd_drive_high, .portd_func_sel, .portd_irq_req);
  gpcd_pin_model u_gpcd_pin_model (.portd_pin_o, .portd_pin_oe_b,
    .portd_pull_up, .portd_pull_down, .ext_level, .portd_pin_in,
    .portd_af_out, .portd_af_oe);

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // reads here see pre-edge values, the design updates in the nba region
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      $display("mismatch at %0t: no pready", $time);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(rdat, exp);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(gpcd_pkg::OFF_D_MODE, 32'h3FF);
    chk(portd_analog_en, 5'h1F);
    rd(gpcd_pkg::OFF_C_FSEL_HI, 32'h0);
    rd(gpcd_pkg::OFF_D_FSEL, 32'h0);
    rd(gpcd_pkg::OFF_C_IRQ_EN, 32'h0);
    rd(gpcd_pkg::OFF_C_IRQ_FLAG, 32'h0);
    rd(gpcd_pkg::OFF_D_IRQ_SENSE, 32'h0);
    rd(gpcd_pkg::OFF_D_IRQ_POL, 32'h0);
    rd(gpcd_pkg::OFF_D_PULL, 32'h0);
    rd(gpcd_pkg::OFF_D_DRV_TYPE, 32'h0);
  endtask

  task automatic t_fsel;
    wr(gpcd_pkg::OFF_C_FSEL_LO, 32'h54321054);
    wr(gpcd_pkg::OFF_C_FSEL_HI, 32'hFEDCBA98);
    wr(gpcd_pkg::OFF_D_FSEL, 32'hFFF43210);
    rd(gpcd_pkg::OFF_C_FSEL_LO, 32'h54321054);
    rd(gpcd_pkg::OFF_D_FSEL, 32'h00043210);
    chk(portc_func_sel, 64'hFEDCBA98_54321054);
    chk(portd_func_sel, 20'h43210);
  endtask

  task automatic t_bits;
    wr(gpcd_pkg::OFF_D_OUT, 32'hFFFFFFEA);
    rd(gpcd_pkg::OFF_D_OUT, 32'h0A);
    wr(gpcd_pkg::OFF_D_BIT_SET, 32'h01);
    wr(gpcd_pkg::OFF_D_BIT_CLR, 32'h03);
    rd(gpcd_pkg::OFF_D_OUT, 32'h08);
    wr(gpcd_pkg::OFF_D_BIT_INV, 32'h1F);
    rd(gpcd_pkg::OFF_D_OUT, 32'h17);
    rd(gpcd_pkg::OFF_D_BIT_SET, 32'h0);
  endtask

  task automatic t_drive;
    wr(gpcd_pkg::OFF_D_MODE, 32'h155);
    tick(2);
    chk(portd_pin_oe_b, 5'h00);
    chk(portd_pin_o, 5'h17);
    rd(gpcd_pkg::OFF_D_IN, 32'h17);
    wr(gpcd_pkg::OFF_D_DRV_TYPE, 32'h1F);
    tick(2);
    chk(portd_pin_oe_b, 5'h17);
    rd(gpcd_pkg::OFF_D_IN, 32'h00);
    wr(gpcd_pkg::OFF_D_PULL, 32'h155);
    tick(2);
    rd(gpcd_pkg::OFF_D_IN, 32'h17);
    wr(gpcd_pkg::OFF_D_MODE, 32'h0);
    wr(gpcd_pkg::OFF_D_PULL, 32'h2AA);
    tick(2);
    chk(portd_pull_down, 5'h1D);
    chk(portd_pull_up, 5'h00);
    ext_level <= 5'h1F;
    tick(3);
    rd(gpcd_pkg::OFF_D_IN, 32'h02);
  endtask

  task automatic t_irq;
    wr(gpcd_pkg::OFF_C_IRQ_SENSE, 32'h18);
    wr(gpcd_pkg::OFF_C_IRQ_POL, 32'h09);
    wr(gpcd_pkg::OFF_C_IRQ_DUAL, 32'h14);
    wr(gpcd_pkg::OFF_C_IRQ_EN, 32'h0F);
    wr(gpcd_pkg::OFF_C_IRQ_FLAG, 32'hFFFF);
    rd(gpcd_pkg::OFF_C_IRQ_FLAG, 32'h10);
    chk(portc_irq_req, 16'h0000);
    portc_pin_in <= 16'h000F;
    tick(3);
    rd(gpcd_pkg::OFF_C_IRQ_FLAG, 32'h1D);
    chk(portc_irq_req, 16'h000D);
    wr(gpcd_pkg::OFF_C_IRQ_FLAG, 32'hFFFF);
    rd(gpcd_pkg::OFF_C_IRQ_FLAG, 32'h18);
    portc_pin_in <= 16'h0000;
    tick(3);
    rd(gpcd_pkg::OFF_C_IRQ_FLAG, 32'h1E);
    wr(gpcd_pkg::OFF_C_IRQ_FLAG, 32'hFFFB);
    rd(gpcd_pkg::OFF_C_IRQ_FLAG, 32'h14);
    wr(gpcd_pkg::OFF_D_IRQ_SENSE, 32'h1);
    wr(gpcd_pkg::OFF_D_IRQ_POL, 32'h1);
    wr(gpcd_pkg::OFF_D_IRQ_EN, 32'h1);
    wr(gpcd_pkg::OFF_D_PULL, 32'h0);
    tick(3);
    wr(gpcd_pkg::OFF_D_IRQ_FLAG, 32'h1F);
    rd(gpcd_pkg::OFF_D_IRQ_FLAG, 32'h01);
    chk(portd_irq_req, 5'h01);
  endtask

  task automatic t_alt;
    wr(gpcd_pkg::OFF_D_DRV_TYPE, 32'h0);
    wr(gpcd_pkg::OFF_D_FSEL, 32'h65310);
    wr(gpcd_pkg::OFF_D_MODE, 32'h2AA);
    wr(gpcd_pkg::OFF_D_DRV_STR, 32'h15);
    tick(2);
    chk(portd_pin_oe_b, 5'h10);
    chk(portd_pin_o & 5'h0F, 5'h0E);
    chk(portd_analog_en, 5'h00);
    chk(portd_drive_high, 5'h15);
    rd(gpcd_pkg::OFF_D_IN, 32'h1E);
    rd(gpcd_pkg::OFF_D_DRV_STR, 32'h0);
  endtask

  task automatic t_err;
    apb(1'b0, 12'h304, 32'h0);
    chk({rerr, rdat}, {1'b1, 32'h0});
    apb(1'b1, 12'h241, 32'h0);
    chk(rerr, 1'b1);
    rd(gpcd_pkg::OFF_C_FSEL_LO, 32'h54321054);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset();
    t_fsel();
    t_bits();
    t_drive();
    t_irq();
    t_alt();
    t_err();
    results();
  end

  // whole run takes well under 1000 cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    results();
  end
endmodule
